// file: verilog/vsd_debug.sv
// Function
// - Debug features are a build option, needing the register port; off removes the logic.
// - Bypass and pattern bits act only when debug is built in.
// - Control bit 4 selects pass-through when 1, normal processing when 0.
// - Pass-through copies each input sample to the output unchanged.
// - Control bit 5 enables the pattern generator when 1.
// - With the generator enabled, its pattern replaces the processed output.
// - First 256 lines of a frame are colour bars, each 64 pixels wide.
// - Bar order black, red, green, yellow, blue, magenta, cyan, white, repeating.
// - Remaining lines hold a monochrome ramp along x and y.
// - Frame counter readable at 0x14, counts frames since reset.
// - Line counter readable at 0x18, counts lines since reset.
// - Pixel counter readable at 0x1c, counts pixels since reset.
// - Last marks the final pixel of each line, input and output.
// - User bit 0 marks the first pixel of each frame.
// - Software reset restores registers, clears state, holds output valid and input ready low.
//
// Purpose: Debug path of a video core: bypass, test pattern, throughput monitors.
// Assumes: One clock; stream ports in the same domain; processing result arrives on proc_*.
//          Generator frame size is held steady while the pattern runs; change it under reset.
//          Width and height are at least one pixel each.
// Notes:   AXI4-Lite slave answers reads and writes in one cycle after both channels present.
//          Control word at 0x00: bit 4 pass-through, bit 5 test pattern, bit 30 software reset.
//          The pattern bit wins over the pass-through bit when both are set.
//          Software reset stands until bit 30 is written back to 0.
//          While it stands, the other control bits fall back to their reset value.
//          Writes to the counter offsets are answered OKAY and change nothing.
//          Unmapped offsets answer SLVERR, and reads of them return zero.
//          Every stream path is combinational, so no beat is ever held inside the block.
`default_nettype none
`include "vsd_regs.svh"
module vsd_debug
  import vsd_pkg::*;
#(
  parameter bit INCLUDE_DEBUG = 1'b1
)
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Frame geometry for the generator.
  input  wire logic [11:0] active_width,
  input  wire logic [11:0] active_height,
  // Input stream slave.
  input  wire logic [23:0] s_axis_video_tdata,
  input  wire logic        s_axis_video_tvalid,
  input  wire logic        s_axis_video_tlast,
  input  wire logic        input_frame_start_flag,
  output logic             s_axis_video_tready,
  // Processing function side.
  input  wire logic [23:0] proc_tdata,
  input  wire logic        proc_tvalid,
  input  wire logic        proc_tlast,
  input  wire logic        proc_tuser,
  output logic             proc_tready,
  input  wire logic        proc_in_ready,
  output logic             proc_in_valid,
  // Output stream master.
  output logic [23:0]      m_axis_video_tdata,
  output logic             m_axis_video_tvalid,
  output logic             m_axis_video_tlast,
  output logic             m_axis_video_tuser,
  input  wire logic        m_axis_video_tready,
  // Software reset seen by the processing function.
  output logic             soft_reset,
  // AXI4-Lite write.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // The register-port state is one struct: the control word and both pending responses.
  // Each response stands until its ready is seen, so a second request of the same kind
  // is held off by the bvalid and rvalid terms of the take conditions below.
  typedef struct packed {
    logic [31:0] control;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } vsd_state_t;
  vsd_state_t st_reg;
  vsd_state_t st_next;

  // Source selection, the chosen beat and the accepted-transfer strobe feed both the
  // stream outputs and the throughput counters, so the counters see exactly what leaves.
  // The counter values are only read through the register port.
  vsd_src_t   src;
  vsd_beat_t  tpg_beat;
  vsd_beat_t  out_beat;
  logic       out_valid;
  logic       xfer;
  logic       wr_go;
  logic       rd_go;
  logic [31:0] frame_throughput_count;
  logic [31:0] line_throughput_count;
  logic [31:0] pixel_throughput_count;

  // Software reset bit in the control register.
  // It is a plain register bit, so it takes effect on the cycle after the write.
  // The processing function sees it too, so both sides flush at the same time.
  assign soft_reset = st_reg.control[`VSD_CTRL_SWRST_BIT];

  // Source choice; without the debug build the processed path is fixed.
  // Priority is pattern, then pass-through, then processing.
  // A downstream core can thus be brought up before anything upstream works.
  // The choice follows the control word at once; switching mid-line tears that line.
  always_comb
  begin
    if (!INCLUDE_DEBUG)
      src = VSD_SRC_PROC;
    else if (st_reg.control[`VSD_CTRL_TPG_BIT])
      src = VSD_SRC_TPG;
    else if (st_reg.control[`VSD_CTRL_BYPASS_BIT])
      src = VSD_SRC_BYPASS;
    else
      src = VSD_SRC_PROC;
  end

  // Output multiplexers in the stream path; bypass and processing flags pass through untouched, the pattern makes its own.
  // The pattern source always offers a beat; its position moves only on an accepted transfer.
  // The defaults keep the multiplexer free of latches for the unused source code.
  // Pass-through keeps the input flags, so line and frame marks stay where upstream put them.
  always_comb
  begin
    out_beat  = '0;
    out_valid = 1'b0;
    unique case (src)
      VSD_SRC_BYPASS:
      begin
        out_beat  = '{s_axis_video_tdata, input_frame_start_flag, s_axis_video_tlast};
        out_valid = s_axis_video_tvalid;
      end
      VSD_SRC_TPG:
      begin
        out_beat  = tpg_beat;
        out_valid = 1'b1;
      end
      VSD_SRC_PROC:
      begin
        out_beat  = '{proc_tdata, proc_tuser, proc_tlast};
        out_valid = proc_tvalid;
      end
    endcase
  end

  // Handshakes; software reset holds output valid and input ready low.
  // Input ready follows whoever consumes the input: the output port in pass-through,
  // the processing function in normal mode.
  // In pattern mode the input is drained and dropped, so the upstream core never stalls.
  // All of these are combinational, which keeps pass-through free of added latency.
  // Downstream must therefore not make its ready depend on our valid in a loop.
  assign m_axis_video_tvalid = out_valid && !soft_reset;
  assign m_axis_video_tdata  = out_beat.data;
  assign m_axis_video_tlast  = out_beat.line_end_marker;
  assign m_axis_video_tuser  = out_beat.frame_start;
  assign xfer                = m_axis_video_tvalid && m_axis_video_tready;
  assign s_axis_video_tready = soft_reset ? 1'b0 :
                               (src == VSD_SRC_BYPASS) ? m_axis_video_tready :
                               (src == VSD_SRC_TPG) ? 1'b1 : proc_in_ready;
  assign proc_in_valid       = s_axis_video_tvalid && !soft_reset && (src == VSD_SRC_PROC);
  assign proc_tready         = (src == VSD_SRC_PROC) && m_axis_video_tready && !soft_reset;

  // Debug logic exists only when built in.
  // The counters watch the beat after the output multiplexer, so they count in every mode.
  // The generator is held cleared whenever it is not the chosen source,
  // so each time the pattern is switched on it starts at the top of a frame.
  // Without the debug build the counters read as zero and no generator exists.
  // The counters wrap silently after 2**32 events; software must read them often enough.
  generate
    if (INCLUDE_DEBUG)
    begin : g_dbg
      vsd_tpg u_tpg (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clear   (soft_reset || src != VSD_SRC_TPG),
        .width   (active_width),
        .height  (active_height),
        .advance (xfer),
        .beat    (tpg_beat)
      );
      vsd_counter u_frame (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clear (soft_reset),
        .inc   (xfer && out_beat.frame_start),
        .count (frame_throughput_count)
      );
      vsd_counter u_line (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clear (soft_reset),
        .inc   (xfer && out_beat.line_end_marker),
        .count (line_throughput_count)
      );
      vsd_counter u_pixel (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clear (soft_reset),
        .inc   (xfer),
        .count (pixel_throughput_count)
      );
    end
    else
    begin : g_nodbg
      assign tpg_beat               = '0;
      assign frame_throughput_count = 32'h0000_0000;
      assign line_throughput_count  = 32'h0000_0000;
      assign pixel_throughput_count = 32'h0000_0000;
    end
  endgenerate

  // Register port: take a write when address and data are both present and no response waits.
  // Ready is combinational on valid, so a request is taken on the first edge it is presented.
  // A lone address or lone data beat waits until its partner arrives.
  // Reads and writes are independent and may be taken on the same edge.
  // No request is refused; an unmapped offset only changes the response code.
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid;
  assign rd_go         = s_axi_arvalid && !st_reg.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rdata   = st_reg.rdata;

  // Register file and responses.
  // A write on a cycle of standing software reset wins, so software can clear bit 30.
  // Only the control word takes byte strobes; the counters are read-only.
  // Read data is captured on the taking edge and stands unchanged until accepted.
  // A counter read therefore shows the value before the beat of that same cycle.
  // Clearing a response and taking a new one cannot meet, as a take needs no standing response.
  // Unmapped reads return zero so no stale data leaks out with the error code.
  always_comb
  begin
    st_next = st_reg;
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    if (wr_go)
    begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = `VSD_RESP_OKAY;
      if (s_axi_awaddr == `VSD_OFF_CONTROL)
      begin
        for (int i = 0; i < 4; i++)
          if (s_axi_wstrb[i])
            st_next.control[8*i +: 8] = s_axi_wdata[8*i +: 8];
      end
      else if (s_axi_awaddr != `VSD_OFF_FRAME_CNT && s_axi_awaddr != `VSD_OFF_LINE_CNT &&
               s_axi_awaddr != `VSD_OFF_PIXEL_CNT)
        st_next.bresp = `VSD_RESP_SLVERR;
    end
    else if (soft_reset)
      st_next.control = `VSD_CTRL_RESET | (32'h0000_0001 << `VSD_CTRL_SWRST_BIT);
    if (rd_go)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `VSD_RESP_OKAY;
      unique case (s_axi_araddr)
        `VSD_OFF_CONTROL:   st_next.rdata = st_reg.control;
        `VSD_OFF_FRAME_CNT: st_next.rdata = frame_throughput_count;
        `VSD_OFF_LINE_CNT:  st_next.rdata = line_throughput_count;
        `VSD_OFF_PIXEL_CNT: st_next.rdata = pixel_throughput_count;
        default:
        begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = `VSD_RESP_SLVERR;
        end
      endcase
    end
  end

  // State register.
  // Hardware reset clears everything, including any standing response.
  // The reset branch loads constants only.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '{control: `VSD_CTRL_RESET, default: '0};
    else
      st_reg <= st_next;
  end
endmodule
`default_nettype wire

// file: verilog/vsd_regs.svh
// Purpose: Offsets, field positions, reset values and sizes of the video stream debug block.
// Assumes: Byte addresses on a 32-bit AXI4-Lite port.
// Notes:   Included by bare name.
`ifndef VSD_REGS_SVH
`define VSD_REGS_SVH
`define VSD_ADDR_W          8
`define VSD_OFF_CONTROL     8'h00
`define VSD_OFF_FRAME_CNT   8'h14
`define VSD_OFF_LINE_CNT    8'h18
`define VSD_OFF_PIXEL_CNT   8'h1c
`define VSD_CTRL_BYPASS_BIT 4
`define VSD_CTRL_TPG_BIT    5
`define VSD_CTRL_SWRST_BIT  30
`define VSD_CTRL_RESET      32'h0000_0000
`define VSD_BAR_LINES       12'h100
`define VSD_BAR_WIDTH_LOG2  6
`define VSD_RESP_OKAY       2'b00
`define VSD_RESP_SLVERR     2'b10
`endif

// file: verilog/vsd_pkg.sv
// Purpose: Types shared by the video stream debug block.
// Assumes: 24-bit pixels, three 8-bit components.
// Notes:   Stream beats travel as one packed struct.
`default_nettype none
package vsd_pkg;
  typedef struct packed {
    logic [23:0] data;
    logic        frame_start;
    logic        line_end_marker;
  } vsd_beat_t;
  typedef enum logic [1:0] {VSD_SRC_PROC, VSD_SRC_BYPASS, VSD_SRC_TPG} vsd_src_t;
endpackage
`default_nettype wire

// file: verilog/vsd_counter.sv
// Purpose: One 32-bit throughput counter.
// Assumes: Single clock, counts on a one-cycle pulse.
// Notes:   Cleared by hardware or software reset.
`default_nettype none
module vsd_counter
  import vsd_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  // Count pulse and value.
  input  wire logic        inc,
  output logic [31:0]      count
);
  typedef struct packed {
    logic [31:0] cnt;
  } vsd_cnt_state_t;
  vsd_cnt_state_t st_reg;
  vsd_cnt_state_t st_next;

  // Next count.
  always_comb
  begin
    st_next = st_reg;
    if (clear)
      st_next.cnt = 32'h0000_0000;
    else if (inc)
      st_next.cnt = st_reg.cnt + 32'h0000_0001;
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign count = st_reg.cnt;
endmodule
`default_nettype wire

// file: verilog/vsd_tpg.sv
// Purpose: Colour-bar and ramp test-pattern generator.
// Assumes: Active size given as width and height in pixels.
// Notes:   Advances only on accepted beats.
`default_nettype none
`include "vsd_regs.svh"
module vsd_tpg
  import vsd_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  // Frame geometry.
  input  wire logic [11:0] width,
  input  wire logic [11:0] height,
  // Output handshake.
  input  wire logic        advance,
  output vsd_beat_t        beat
);
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
  } vsd_tpg_state_t;
  vsd_tpg_state_t st_reg;
  vsd_tpg_state_t st_next;
  logic [2:0] bar;
  logic [7:0] ramp;

  // Position counters step per accepted pixel and wrap at line and frame ends.
  always_comb
  begin
    st_next = st_reg;
    if (clear)
      st_next = '0;
    else if (advance)
    begin
      if (st_reg.x >= width - 12'h001)
      begin
        st_next.x = 12'h000;
        st_next.y = (st_reg.y >= height - 12'h001) ? 12'h000 : st_reg.y + 12'h001;
      end
      else
        st_next.x = st_reg.x + 12'h001;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Bar index from x: black, red, green, yellow, blue, magenta, cyan, white, repeating.
  assign bar  = st_reg.x[`VSD_BAR_WIDTH_LOG2 +: 3];
  assign ramp = st_reg.x[7:0] + st_reg.y[7:0];

  // Pixel value and flags; components are {red, green, blue}.
  always_comb
  begin
    if (st_reg.y < `VSD_BAR_LINES)
      beat.data = {{8{bar[0]}}, {8{bar[1]}}, {8{bar[2]}}};
    else
      beat.data = {ramp, ramp, ramp};
    beat.frame_start     = (st_reg.x == 12'h000) && (st_reg.y == 12'h000);
    beat.line_end_marker = (st_reg.x >= width - 12'h001);
  end
endmodule
`default_nettype wire

// file: sim/vsd_stream_partner.sv
// Purpose: Upstream source and downstream sink around the debug block.
// Assumes: The source sends one frame of W by H pixels once go is set.
// Notes:   Idle data shows the inverse of the last beat.
`default_nettype none
module vsd_stream_partner
  import vsd_pkg::*;
#(
  parameter int W = 4,
  parameter int H = 2
)
(
  // Clock, reset and test control.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic        stall,
  // Upstream source.
  output logic [23:0]      tdata,
  output logic             tvalid,
  output logic             tlast,
  output logic             tuser,
  input  wire logic        tready,
  // Downstream sink.
  output logic             m_tready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] idx_reg;
  logic        tog_reg;
  // A beat and its flags hold until accepted.
  assign tvalid = go && (idx_reg < 16'(W * H));
  assign tdata  = tvalid ? 24'(idx_reg) + 24'h000100 : ~(24'(idx_reg) + 24'h0000ff);
  assign tlast  = tvalid && (idx_reg % 16'(W) == 16'(W - 1));
  assign tuser  = tvalid && (idx_reg == 16'h0000);
  // The sink stalls every other cycle when asked.
  assign m_tready = !stall || tog_reg;
  // Beat index and stall phase.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_reg <= 16'h0000;
      tog_reg <= 1'b0;
    end
    else
    begin
      idx_reg <= idx_reg + 16'(tvalid && tready);
      tog_reg <= !tog_reg;
    end
  end
endmodule
`default_nettype wire

// file: sim/vsd_debug_assertions.sv
// Purpose: Port assertions of the debug block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every instance of the block.
`default_nettype none
module vsd_debug_assertions
  import vsd_pkg::*;
(
  // Clock, reset and software reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        soft_reset,
  // Streams.
  input  wire logic        s_axis_video_tvalid,
  input  wire logic        s_axis_video_tready,
  input  wire logic [23:0] m_axis_video_tdata,
  input  wire logic        m_axis_video_tvalid,
  input  wire logic        m_axis_video_tready,
  // Register port.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wt;
  logic rt;
  // Requests taken by the register port.
  assign wt = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign rt = s_axi_arvalid && !s_axi_rvalid;
  AST_WR_ANSWER: assert property (wt |=> s_axi_bvalid)
    else $error("write not answered");
  AST_RD_ANSWER: assert property (rt |=> s_axi_rvalid)
    else $error("read not answered");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  AST_UNMAPPED: assert property (rt && !(s_axi_araddr inside {8'h00, 8'h14, 8'h18, 8'h1c})
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000)
    else $error("unmapped read answered");
  AST_SWRST_SET: assert property (wt && s_axi_awaddr == 8'h00 && s_axi_wstrb[3] && s_axi_wdata[30] |=> soft_reset)
    else $error("soft reset not set");
  AST_SWRST_QUIET: assert property (soft_reset |-> !m_axis_video_tvalid && !s_axis_video_tready)
    else $error("stream active in soft reset");
  AST_OUT_HOLD: assert property (m_axis_video_tvalid && !m_axis_video_tready && !wt |=> $stable(m_axis_video_tdata))
    else $error("output beat changed while stalled");
  // Main scenarios reached.
  cover property (s_axis_video_tvalid && s_axis_video_tready && m_axis_video_tvalid);
  cover property (m_axis_video_tvalid && !m_axis_video_tready);
  cover property ($rose(soft_reset));
endmodule
bind vsd_debug vsd_debug_assertions u_vsd_debug_assertions (.*);
`default_nettype wire

// file: sim/vsd_debug_tb.sv
// Purpose: Self-checking bench of the debug block.
// Assumes: Register reads and writes through the block's own port.
// Notes:   Output beats are checked as they are accepted.
`default_nettype none
`define VSD_CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
      err_total++; \
      $display("unexpected %s: expected %h, seen %h", nm, ex, got); \
    end \
  end
module vsd_debug_tb
  import vsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, rst_n = 1'b0, go = 1'b0, stall = 1'b0;
  logic [11:0] active_width = 12'h208, active_height = 12'h002, tx = 12'h000, ty = 12'h000;
  logic [23:0] proc_tdata, s_axis_video_tdata, m_axis_video_tdata;
  logic        proc_tvalid = 1'b0, proc_tlast = 1'b0, proc_tuser = 1'b0, proc_in_ready = 1'b1;
  logic        s_axis_video_tvalid, s_axis_video_tlast, input_frame_start_flag, s_axis_video_tready;
  logic        proc_tready, proc_in_valid, m_axis_video_tvalid, m_axis_video_tlast, m_axis_video_tuser;
  logic        m_axis_video_tready, soft_reset, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, gv;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, md = 2'd0;
  logic [2:0]  ci;
  int          tests_run = 0, err_total = 0, cycles = 0;
  // Processing result differs from the input so bypass is visible.
  assign proc_tdata = ~s_axis_video_tdata;
  always #5 mclk = ~mclk;
  vsd_debug #(.INCLUDE_DEBUG(1'b1)) u_vsd_debug (.*);
  vsd_stream_partner #(.W(4), .H(2)) u_vsd_stream_partner (.mclk(mclk), .rst_n(rst_n), .go(go),
    .stall(stall), .tdata(s_axis_video_tdata), .tvalid(s_axis_video_tvalid), .tlast(s_axis_video_tlast),
    .tuser(input_frame_start_flag), .tready(s_axis_video_tready), .m_tready(m_axis_video_tready));
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Register write; the request holds until taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge mclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge mclk);
    s_axi_bready <= 1'b0;
    `VSD_CHK("bresp", 2'b00, s_axi_bresp)
  endtask
  // Register read against an expected value and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge mclk);
    s_axi_rready <= 1'b0;
    `VSD_CHK("rdata", ed, s_axi_rdata)
    `VSD_CHK("rresp", er, s_axi_rresp)
  endtask
  // Output checks per mode and the hang limit.
  always @(posedge mclk)
  begin
    cycles++;
    ci = tx[8:6];
    gv = tx[7:0] + ty[7:0];
    if (soft_reset === 1'b1)
    begin
      tx <= 12'h000;
      ty <= 12'h000;
    end
    if (md == 2'd1)
      `VSD_CHK("bypass valid", s_axis_video_tvalid, m_axis_video_tvalid)
    if (md == 2'd1 && m_axis_video_tvalid === 1'b1 && m_axis_video_tready === 1'b1)
    begin
      `VSD_CHK("bypass data", s_axis_video_tdata, m_axis_video_tdata)
      `VSD_CHK("bypass last", s_axis_video_tlast, m_axis_video_tlast)
      `VSD_CHK("bypass user", input_frame_start_flag, m_axis_video_tuser)
    end
    if (md == 2'd2 && soft_reset === 1'b0)
    begin
      `VSD_CHK("pattern valid", 1'b1, m_axis_video_tvalid)
      if (m_axis_video_tready === 1'b1)
      begin
        `VSD_CHK("pattern data", (ty < 12'h100) ? {{8{ci[0]}}, {8{ci[1]}}, {8{ci[2]}}} : {gv, gv, gv},
          m_axis_video_tdata)
        `VSD_CHK("pattern user", tx == 12'h000 && ty == 12'h000, m_axis_video_tuser)
        `VSD_CHK("pattern last", tx == active_width - 12'h001, m_axis_video_tlast)
        tx <= (tx == active_width - 12'h001) ? 12'h000 : tx + 12'h001;
        if (tx == active_width - 12'h001)
          ty <= (ty == active_height - 12'h001) ? 12'h000 : ty + 12'h001;
      end
    end
    if (md == 2'd0 && proc_tvalid === 1'b1)
    begin
      `VSD_CHK("proc valid", 1'b1, m_axis_video_tvalid)
      `VSD_CHK("proc data", proc_tdata, m_axis_video_tdata)
      `VSD_CHK("proc ready", m_axis_video_tready, proc_tready)
      `VSD_CHK("proc input valid", s_axis_video_tvalid, proc_in_valid)
    end
    // The hang limit counts as a mismatch and ends the run.
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  // Test sequence.
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(8'h00, 32'h0, 2'b00);
    rd(8'h14, 32'h0, 2'b00);
    rd(8'h1c, 32'h0, 2'b00);
    rd(8'h04, 32'h0, 2'b10);
    $display("test reset done");
    wr(8'h00, 32'h10);
    md <= 2'd1;
    go <= 1'b1;
    stall <= 1'b1;
    do @(posedge mclk); while (s_axis_video_tvalid !== 1'b0);
    md <= 2'd0;
    rd(8'h14, 32'h1, 2'b00);
    rd(8'h18, 32'h2, 2'b00);
    rd(8'h1c, 32'h8, 2'b00);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h1, 2'b00);
    $display("test bypass done");
    wr(8'h00, 32'h40000000);
    md <= 2'd2;
    `VSD_CHK("reset valid", 1'b0, m_axis_video_tvalid)
    `VSD_CHK("reset ready", 1'b0, s_axis_video_tready)
    rd(8'h1c, 32'h0, 2'b00);
    $display("test soft reset done");
    wr(8'h00, 32'h20);
    do @(posedge mclk); while (ty == 12'h000);
    wr(8'h00, 32'h40000020);
    active_width <= 12'h004;
    active_height <= 12'h102;
    wr(8'h00, 32'h30);
    do @(posedge mclk); while (ty != 12'h101);
    do @(posedge mclk); while (ty != 12'h000);
    repeat (6) @(posedge mclk);
    $display("test pattern done");
    md <= 2'd0;
    wr(8'h00, 32'h0);
    proc_tvalid <= 1'b1;
    repeat (6) @(posedge mclk);
    $display("test processing done");
    complete_run();
  end
endmodule
`undef VSD_CHK
`default_nettype wire
